// ---- design/touch_pkg.sv ----
// Purpose: shared constants and carrier types for the resistive touch acquisition block
// Assumes: 100 MHz mclk, bias switch pins driven by analog switch drivers outside
// Notes: settle time counts are in mclk cycles, taken from the configured bias_settle_time
//
// How it works
// - wiring select input picks 4-wire or 5-wire switch and sense setups.
// - 4-wire Y: bias top sheet, sense horizontal positive terminal, other sheet floating.
// - 4-wire X: bias bottom sheet, sense top sheet through a vertical terminal.
// - every result is an unsigned 12-bit ratiometric code, full scale 4095.
// - 5-wire: bias opposite corner pairs, convert the wiper sense line.
// - 4-wire offers two contact ratio setups, first and second.
// - no contact ratio setups exist when wired for a 5-wire panel.
// - raw contact ratio codes only; host computes contact resistance.
// - wait programmed bias settle time after biasing before each conversion.
// - pen detection biases for one eighth of the settle time plus the synchroniser depth before sampling.
// - 4-wire detect: pull up horizontal positive, ground vertical negative, compare digitally.
// - 5-wire detect: pull up shared corner pin, ground top sheet via wiper.
// - pull-up resistor selectable among four settings.
// - touch sets contact present flag, interrupt if unmasked.
// - release clears contact present flag, interrupt if unmasked.
// - touch interrupts in watch mode, starts acquisition in triggered mode.
// - proximity sensing suspended while touch present, resumed after.
// - pen detection precedes conversions so no data reach host without contact.
// - after reset the block is in host driven mode and idle.
// - host driven: detect after each convert, skip if no contact, flag unchanged.
// - sequence: bias each channel for settle time, remove bias after conversion.
// - watch mode: continuous detection when up, at poll rate when down, no conversions.
package touch_pkg;
   localparam int ADC_BITS = 12;
   localparam logic [ADC_BITS-1:0] ADC_FULL = 12'hFFF; // 4095
   localparam int DLY_BITS = 16;
   localparam int RATE_BITS = 20;
   localparam int CH_NUM = 4;
   localparam int CH_BITS = 2;
   localparam int PDET_SHIFT = 3; // one eighth
   localparam int SYNC_STAGES = 3; // comparator synchroniser depth, not counting the filter register
   localparam int SW_NUM = 10;

   // switch vector bit positions
   localparam int SW_XP_REF = 0; // horizontal positive / corner bottom right to vref
   localparam int SW_XN_GND = 1; // horizontal negative / corner bottom left to gnd
   localparam int SW_YP_REF = 2; // vertical positive / corner top right to vref
   localparam int SW_YN_GND = 3; // vertical negative / corner top left to gnd
   localparam int SW_XP_PU = 4;  // pull-up on horizontal positive / corner bottom right
   localparam int SW_YN_PD = 5;  // vertical negative grounded for detection
   localparam int SW_WIP_GND = 6;// wiper grounded for detection
   localparam int SW_XN_REF = 7; // corner bottom left to vref (5-wire Y)
   localparam int SW_YP_GND = 8; // corner top right to gnd (not used by any setup)
   localparam int SW_XP_GND = 9; // ground on horizontal positive / corner bottom right (5-wire Y)

   // sense multiplexer selections
   localparam logic [1:0] SNS_XP = 2'h0;
   localparam logic [1:0] SNS_YP = 2'h1;
   localparam logic [1:0] SNS_XN = 2'h2;
   localparam logic [1:0] SNS_WIPER = 2'h3;

   // channel indexes
   localparam logic [CH_BITS-1:0] CH_X = 2'h0;
   localparam logic [CH_BITS-1:0] CH_Y = 2'h1;
   localparam logic [CH_BITS-1:0] CH_Z1 = 2'h2;
   localparam logic [CH_BITS-1:0] CH_Z2 = 2'h3;

   typedef enum logic [1:0] {MODE_HOST, MODE_WATCH, MODE_TRIG} opMode_e;

   typedef struct packed {
      logic [SW_NUM-1:0] sw;
      logic [1:0] sense;
   } panelDrive_s;

   typedef struct packed {
      logic [CH_BITS-1:0] chan;
      logic [ADC_BITS-1:0] code;
   } result_s;
endpackage

// ---- design/panel_setup.sv ----
// Purpose: maps a channel or detection request to switch settings and sense select
// Assumes: purely combinational, consumer drives the result out unregistered
// Notes: unknown or disallowed setups open every switch
`timescale 1ns/1ns
module panel_setup
   import touch_pkg::*;
(
   input wire logic fiveWire,
   input wire logic active,
   input wire logic detect,
   input wire logic [CH_BITS-1:0] chan,
   output panelDrive_s drive
);
   // one decode for all setups keeps conversion and detection mutually exclusive
   always_comb begin
      drive = '0;
      if (active && detect) begin
         drive.sw[SW_XP_PU] = 1'b1;
         if (fiveWire) begin
            drive.sw[SW_WIP_GND] = 1'b1;
         end else begin
            drive.sw[SW_YN_PD] = 1'b1;
         end
      end else if (active && !fiveWire) begin
         case (chan)
            CH_Y: begin
               drive.sw[SW_YP_REF] = 1'b1;
               drive.sw[SW_YN_GND] = 1'b1;
               drive.sense = SNS_XP;
            end
            CH_X: begin
               drive.sw[SW_XP_REF] = 1'b1;
               drive.sw[SW_XN_GND] = 1'b1;
               drive.sense = SNS_YP;
            end
            CH_Z1: begin
               drive.sw[SW_YP_REF] = 1'b1;
               drive.sw[SW_XN_GND] = 1'b1;
               drive.sense = SNS_XP;
            end
            default: begin
               drive.sw[SW_YP_REF] = 1'b1;
               drive.sw[SW_XN_GND] = 1'b1;
               drive.sense = SNS_XN;
            end
         endcase
      end else if (active) begin
         case (chan)
            CH_X: begin
               drive.sw[SW_XP_REF] = 1'b1;
               drive.sw[SW_YP_REF] = 1'b1;
               drive.sw[SW_XN_GND] = 1'b1;
               drive.sw[SW_YN_GND] = 1'b1;
               drive.sense = SNS_WIPER;
            end
            CH_Y: begin
               drive.sw[SW_YP_REF] = 1'b1;
               drive.sw[SW_XN_REF] = 1'b1;
               drive.sw[SW_XP_GND] = 1'b1;
               drive.sw[SW_YN_GND] = 1'b1;
               drive.sense = SNS_WIPER;
            end
            default: begin
               drive = '0;
            end
         endcase
      end
   end
endmodule

// ---- design/touch_acq.sv ----
// Purpose: sequences pen detection, bias, settle and conversion for a resistive panel
// Assumes: adc handshake on mclk; comparator arrives asynchronously from the pad
// Notes: codes are passed raw, no averaging here
`timescale 1ns/1ns
module touch_acq
   import touch_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic fiveWire,
   input wire logic [1:0] pullupSel,
   input wire logic [DLY_BITS-1:0] biasSettleTime,
   input wire logic [RATE_BITS-1:0] touchPollRate,
   input wire logic [CH_NUM-1:0] seqMask,
   input wire logic cmdHost,
   input wire logic cmdWatch,
   input wire logic cmdTrig,
   input wire logic cmdConvert,
   input wire logic [CH_NUM-1:0] convMask,
   input wire logic penCompIn,
   input wire logic [1:0] penMask,
   output logic adcStart,
   input wire logic adcDone,
   input wire logic [ADC_BITS-1:0] adcCode,
   output panelDrive_s panelDrive,
   output logic [1:0] pullupCode,
   output result_s result,
   output logic resultValid,
   output logic contactPresentFlag,
   output logic [1:0] contactEvents,
   output logic contactIrq,
   output logic proxEnable,
   output logic busy
);
   typedef enum {ST_IDLE, ST_PDET, ST_PSAMP, ST_PICK, ST_BIAS, ST_CONV, ST_WAIT} state_e;

   state_e state_r, state_nxt;
   opMode_e mode_r, mode_nxt;
   logic [CH_NUM-1:0] pend_r, pend_nxt;
   logic [CH_BITS-1:0] chan_r, chan_nxt;
   logic [DLY_BITS-1:0] cnt_r, cnt_nxt;
   logic [RATE_BITS-1:0] rate_r, rate_nxt;
   logic flag_r, flag_nxt;
   logic [1:0] evt_r, evt_nxt;
   result_s res_r, res_nxt;
   logic resV_r, resV_nxt;
   logic hostReq_r, hostReq_nxt;
   logic [2:0] comp_r;
   logic penNow_r, penNow_nxt;
   logic detect, active;
   logic [DLY_BITS-1:0] detDly;
   logic [CH_NUM-1:0] allowMask;
   panelDrive_s driveComb;

   // three-stage synchroniser; a change counts once stages two and three agree
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         comp_r <= '0;
      end else begin
         comp_r <= {comp_r[1:0], penCompIn};
      end
   end

   // filtered comparator level
   always_comb begin
      penNow_nxt = penNow_r;
      if (comp_r[1] == comp_r[2]) begin
         penNow_nxt = comp_r[2];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         penNow_r <= 1'b0;
      end else begin
         penNow_r <= penNow_nxt;
      end
   end

   assign detDly = biasSettleTime >> PDET_SHIFT;
   assign detect = (state_r == ST_PDET) || (state_r == ST_PSAMP);
   assign active = detect || (state_r == ST_BIAS) || (state_r == ST_CONV);
   // contact ratio channels vanish on 5-wire panels
   assign allowMask = fiveWire ? {2'b00, 2'b11} : {CH_NUM{1'b1}};

   panel_setup uSetup (
      .fiveWire(fiveWire),
      .active(active),
      .detect(detect),
      .chan(chan_r),
      .drive(driveComb)
   );

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      pend_nxt = pend_r;
      chan_nxt = chan_r;
      cnt_nxt = cnt_r;
      rate_nxt = rate_r;
      flag_nxt = flag_r;
      evt_nxt = '0;
      res_nxt = res_r;
      resV_nxt = 1'b0;
      hostReq_nxt = hostReq_r;
      if (cmdHost) begin
         mode_nxt = MODE_HOST;
      end else if (cmdWatch) begin
         mode_nxt = MODE_WATCH;
      end else if (cmdTrig) begin
         mode_nxt = MODE_TRIG;
      end
      if (rate_r != '0) begin
         rate_nxt = rate_r - 1'b1;
      end
      case (state_r)
         ST_IDLE: begin
            cnt_nxt = '0;
            if (mode_r == MODE_HOST && cmdConvert && (convMask & allowMask) != '0) begin
               pend_nxt = convMask & allowMask;
               hostReq_nxt = 1'b1;
               state_nxt = ST_PDET;
            end else if (mode_r != MODE_HOST && (!flag_r || rate_r == '0)) begin
               hostReq_nxt = 1'b0;
               state_nxt = ST_PDET;
            end
         end
         ST_PDET: begin
            cnt_nxt = cnt_r + 1'b1;
            // also wait out the synchroniser, else a short bias judges the level of the last check
            if (cnt_r >= detDly + DLY_BITS'(SYNC_STAGES)) begin
               state_nxt = ST_PSAMP;
            end
         end
         ST_PSAMP: begin
            // one cycle with switches still set lets the filtered level settle in
            cnt_nxt = '0;
            rate_nxt = touchPollRate;
            state_nxt = ST_IDLE;
            if (hostReq_r) begin
               hostReq_nxt = 1'b0;
               if (penNow_r) begin
                  state_nxt = ST_PICK;
               end else begin
                  pend_nxt = '0;
               end
            end else begin
               if (penNow_r != flag_r) begin
                  flag_nxt = penNow_r;
                  evt_nxt = {!penNow_r, penNow_r};
               end
               if (mode_r == MODE_TRIG && penNow_r) begin
                  pend_nxt = seqMask & allowMask;
                  state_nxt = ST_PICK;
               end
            end
         end
         ST_PICK: begin
            state_nxt = ST_IDLE;
            for (int i = CH_NUM - 1; i >= 0; i--) begin
               if (pend_r[i]) begin
                  chan_nxt = CH_BITS'(i);
                  state_nxt = ST_BIAS;
               end
            end
         end
         ST_BIAS: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r >= biasSettleTime) begin
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (adcDone) begin
               res_nxt.chan = chan_r;
               res_nxt.code = adcCode;
               resV_nxt = 1'b1;
               pend_nxt[chan_r] = 1'b0;
               cnt_nxt = '0;
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // bias is off for two cycles between channels, here and in ST_PICK
            state_nxt = ST_PICK;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (cmdHost || cmdWatch || cmdTrig) begin
         state_nxt = ST_IDLE;
         pend_nxt = '0;
         hostReq_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
         mode_r <= MODE_HOST;
         pend_r <= '0;
         chan_r <= CH_X;
         cnt_r <= '0;
         rate_r <= '0;
         flag_r <= 1'b0;
         evt_r <= '0;
         res_r <= '0;
         resV_r <= 1'b0;
         hostReq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         chan_r <= chan_nxt;
         cnt_r <= cnt_nxt;
         rate_r <= rate_nxt;
         flag_r <= flag_nxt;
         evt_r <= evt_nxt;
         res_r <= res_nxt;
         resV_r <= resV_nxt;
         hostReq_r <= hostReq_nxt;
      end
   end

   // outputs; switches follow registered state so they open with the idle state
   assign panelDrive = driveComb;
   assign pullupCode = pullupSel;
   assign adcStart = (state_r == ST_CONV);
   assign result = res_r;
   assign resultValid = resV_r;
   assign contactPresentFlag = flag_r;
   assign contactEvents = evt_r;
   // interrupt pulse only in watch mode; trig mode starts acquisition instead
   assign contactIrq = (mode_r == MODE_WATCH) && ((evt_r & penMask) != '0);
   assign proxEnable = !flag_r;
   assign busy = (state_r != ST_IDLE);
endmodule

// ---- test/touch_acq_asserts.sv ----
// Purpose: port checks for touch_acq
// Assumes: fiveWire and biasSettleTime stay still while busy
// Notes: bias length is counted in helper logic
`timescale 1ns/1ns
module touch_acq_asserts
   import touch_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic fiveWire,
   input wire logic [DLY_BITS-1:0] biasSettleTime,
   input wire logic [1:0] penMask,
   input wire logic adcStart,
   input wire logic adcDone,
   input wire logic [ADC_BITS-1:0] adcCode,
   input wire panelDrive_s panelDrive,
   input wire result_s result,
   input wire logic resultValid,
   input wire logic contactPresentFlag,
   input wire logic [1:0] contactEvents,
   input wire logic contactIrq,
   input wire logic proxEnable,
   input wire logic busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [DLY_BITS:0] held_r;
   logic [DLY_BITS:0] held_nxt;
   // bias cycles ahead of a conversion; any open cycle restarts the count
   always_comb begin
      held_nxt = '0;
      if (panelDrive.sw != '0 && !adcStart) held_nxt = held_r + 1'b1;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) held_r <= '0;
      else held_r <= held_nxt;
   end
   sequence s_convEnd; adcStart && adcDone; endsequence
   sequence s_touch; $rose(contactPresentFlag); endsequence
   property p_idle; !busy |-> panelDrive.sw == '0 && !adcStart; endproperty
   a_idle: assert property (p_idle) else $error("bias while idle");
   property p_result; s_convEnd |=> resultValid && result.code == $past(adcCode) && panelDrive.sw == '0; endproperty
   a_result: assert property (p_result) else $error("result or release wrong");
   property p_settle; $rose(adcStart) |-> held_r >= biasSettleTime; endproperty
   a_settle: assert property (p_settle) else $error("conversion before settle");
   property p_detect; panelDrive.sw[SW_XP_PU] |->
      !adcStart && (fiveWire ? panelDrive.sw[SW_WIP_GND] : panelDrive.sw[SW_YN_PD]); endproperty
   a_detect: assert property (p_detect) else $error("detect setup wrong");
   property p_prox; proxEnable != contactPresentFlag; endproperty
   a_prox: assert property (p_prox) else $error("proximity enable wrong");
   property p_fiveXY; resultValid && fiveWire |-> (result.chan == CH_X || result.chan == CH_Y); endproperty
   a_fiveXY: assert property (p_fiveXY) else $error("pressure on 5-wire");
   property p_touch; s_touch |-> contactEvents == 2'b01; endproperty
   a_touch: assert property (p_touch) else $error("touch event missing");
   property p_release; $fell(contactPresentFlag) |-> contactEvents == 2'b10; endproperty
   a_release: assert property (p_release) else $error("release event missing");
   property p_evt; contactEvents != 2'b00 |-> $changed(contactPresentFlag); endproperty
   a_evt: assert property (p_evt) else $error("event without change");
   property p_irq; contactIrq |-> (contactEvents & penMask) != 2'b00; endproperty
   a_irq: assert property (p_irq) else $error("irq not unmasked");
endmodule

bind touch_acq touch_acq_asserts touch_acq_asserts_inst (.mclk(mclk), .arst_n(arst_n), .fiveWire(fiveWire),
   .biasSettleTime(biasSettleTime), .penMask(penMask), .adcStart(adcStart), .adcDone(adcDone),
   .adcCode(adcCode), .panelDrive(panelDrive), .result(result), .resultValid(resultValid),
   .contactPresentFlag(contactPresentFlag), .contactEvents(contactEvents), .contactIrq(contactIrq),
   .proxEnable(proxEnable), .busy(busy));

// ---- test/panel_model.sv ----
// Purpose: panel and converter stand-in for touch_acq
// Assumes: comparator reads touched only while the pull-up is on
// Notes: converter latency is set per test
`timescale 1ns/1ns
module panel_model
   import touch_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire panelDrive_s panelDrive,
   input wire logic adcStart,
   input wire logic touched,
   input wire logic [3:0] lat,
   input wire logic [ADC_BITS-1:0] codeIn,
   output logic penCompIn,
   output logic adcDone,
   output logic [ADC_BITS-1:0] adcCode
);
   logic [3:0] cnt;
   logic wander;
   // without the pull-up the sense pin floats, so the comparator wanders
   assign penCompIn = panelDrive.sw[SW_XP_PU] ? touched : wander;
   // converter answers lat+1 cycles after start, once per start
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
         wander <= 1'b0;
         adcDone <= 1'b0;
         adcCode <= '0;
      end else begin
         wander <= ~wander;
         adcDone <= adcStart && cnt == lat;
         adcCode <= (adcStart && cnt == lat) ? codeIn : ~adcCode; // stale code never lingers
         cnt <= !adcStart ? 4'h0 : cnt + 4'(cnt <= lat);
      end
   end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for touch_acq
// Assumes: panel_model stands for panel and converter
// Notes: results are matched in order against a queue of notes
`timescale 1ns/1ns
module tb
   import touch_pkg::*;
;
   logic mclk, arst_n, fiveWire, cmdHost, cmdWatch, cmdTrig, cmdConvert, touched;
   logic penCompIn, adcStart, adcDone, resultValid, flag, irq, prox, busy;
   logic [1:0] pullupSel, penMask, pullupCode, events;
   logic [DLY_BITS-1:0] settle;
   logic [RATE_BITS-1:0] rate;
   logic [CH_NUM-1:0] seqMask, convMask;
   logic [3:0] lat;
   logic [7:0] idx = 8'h00;
   logic [ADC_BITS-1:0] adcCode;
   logic [ADC_BITS-1:0] codeTab [256];
   panelDrive_s drive;
   result_s result;
   result_s expQ[$];
   int n_mismatch, cmp_count, cyc, nIrq, nConv, i;
   touch_acq touch_acq_inst (.mclk(mclk), .arst_n(arst_n), .fiveWire(fiveWire), .pullupSel(pullupSel),
      .biasSettleTime(settle), .touchPollRate(rate), .seqMask(seqMask), .cmdHost(cmdHost),
      .cmdWatch(cmdWatch), .cmdTrig(cmdTrig), .cmdConvert(cmdConvert), .convMask(convMask),
      .penCompIn(penCompIn), .penMask(penMask), .adcStart(adcStart), .adcDone(adcDone), .adcCode(adcCode),
      .panelDrive(drive), .pullupCode(pullupCode), .result(result), .resultValid(resultValid),
      .contactPresentFlag(flag), .contactEvents(events), .contactIrq(irq), .proxEnable(prox), .busy(busy));
   panel_model panel_model_inst (.mclk(mclk), .arst_n(arst_n), .panelDrive(drive), .adcStart(adcStart),
      .touched(touched), .lat(lat), .codeIn(codeTab[idx]), .penCompIn(penCompIn), .adcDone(adcDone),
      .adcCode(adcCode));
   // compare helpers
   task automatic chkVec(string nm, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (e !== g) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chkBit(string nm, logic e, logic g);
      cmp_count++;
      if (e !== g) begin
         n_mismatch++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chkRes(result_s e, result_s g);
      chkVec("result", 16'(e), 16'(g));
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // drivers move 1 ns after the edge
   task automatic step(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic pushSeq(logic [3:0] m);
      for (int c = 0; c < 4; c++) begin
         if (m[c] && !(fiveWire && c > 1)) begin
            expQ.push_back({2'(c), codeTab[nConv]});
            nConv++;
         end
      end
   endtask
   task automatic waitIdle(int lim);
      for (int k = 0; k < lim && (busy !== 1'b0 || expQ.size() > 0); k++) step(1);
      chkVec("pending", 16'h0000, 16'(expQ.size()));
      chkBit("idle", 1'b0, busy);
   endtask
   task automatic waitFlag(logic v, int lim);
      for (int k = 0; k < lim && flag !== v; k++) step(1);
      step(2);
      chkBit("flag", v, flag);
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // watcher: hang limit, irq count, in-order results, setup seen as each X or Y conversion ends
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 60000) begin
         n_mismatch++;
         end_sim();
      end
      if (arst_n && irq === 1'b1) nIrq++;
      if (arst_n && resultValid && expQ.size() == 0) chkBit("extra", 1'b0, 1'b1);
      else if (arst_n && resultValid) chkRes(expQ.pop_front(), result);
      if (adcStart && adcDone) idx <= idx + 8'd1;
      if (adcStart && adcDone && expQ.size() > 0 && expQ[0].chan < CH_Z1) begin
         chkVec("sense", 16'(fiveWire ? SNS_WIPER : expQ[0].chan == CH_X ? SNS_YP : SNS_XP),
            16'(drive.sense));
         if (!fiveWire) chkVec("bias", expQ[0].chan == CH_X ? 16'h0003 : 16'h000c, 16'({drive.sw[SW_YP_REF],
            drive.sw[SW_YN_GND], drive.sw[SW_XP_REF], drive.sw[SW_XN_GND]}));
      end
   end
   // main sequence
   initial begin
      void'($urandom(32'h7ae6));
      {arst_n, fiveWire, cmdHost, cmdWatch, cmdTrig, cmdConvert, touched} = '0;
      {seqMask, convMask, penMask, lat} = '0;
      pullupSel = 2'b11;
      settle = 16'h0010 + 16'($urandom % 32);
      rate = 20'h0_0200;
      for (i = 0; i < 256; i++) codeTab[i] = 12'($urandom);
      codeTab[1] = 12'h0fff;
      codeTab[2] = 12'h0000;
      step(2);
      arst_n = 1'b1;
      chkBit("prox", 1'b1, prox);
      chkBit("open", 1'b1, drive.sw === '0 && busy === 1'b0);
      // all four channels; a second convert while busy is ignored
      touched = 1'b1;
      convMask = 4'hf;
      pushSeq(convMask);
      pulse(cmdConvert);
      step(3);
      pulse(cmdConvert);
      waitIdle(3000);
      chkBit("flag", 1'b0, flag);
      // random masks, alternating wiring, two rounds without contact
      for (i = 0; i < 8; i++) begin
         fiveWire = i[0];
         touched = (i != 2 && i != 5);
         lat = 4'($urandom % 8);
         convMask = 4'($urandom);
         pullupSel = 2'($urandom);
         if (touched) pushSeq(convMask);
         pulse(cmdConvert);
         waitIdle(3000);
         chkVec("pullup", 16'(pullupSel), 16'(pullupCode));
      end
      // watch mode: one irq per change, none while contact persists or when masked
      fiveWire = 1'b0;
      touched = 1'b0;
      penMask = 2'b11;
      pulse(cmdWatch);
      step(40);
      touched = 1'b1;
      waitFlag(1'b1, 300);
      chkBit("prox", 1'b0, prox);
      step(1500);
      chkVec("irqs", 16'd1, 16'(nIrq));
      touched = 1'b0;
      waitFlag(1'b0, 800);
      chkVec("irqs", 16'd2, 16'(nIrq));
      penMask = 2'b00;
      touched = 1'b1;
      waitFlag(1'b1, 300);
      chkVec("irqs", 16'd2, 16'(nIrq));
      // triggered mode: a touch starts the chosen sequence, then host mode is restored once it completes
      touched = 1'b0;
      seqMask = 4'($urandom) | 4'h1;
      pulse(cmdTrig);
      waitFlag(1'b0, 800);
      pushSeq(seqMask);
      touched = 1'b1;
      for (i = 0; i < 3000 && expQ.size() > 0; i++) step(1);
      pulse(cmdHost);
      waitIdle(100);
      // reset again from watch mode with contact held; host mode and idle must come back
      pulse(cmdWatch);
      step(3);
      arst_n = 1'b0;
      step(1);
      arst_n = 1'b1;
      chkBit("flag", 1'b0, flag);
      chkBit("prox", 1'b1, prox);
      step(20);
      chkBit("busy", 1'b0, busy);
      chkVec("drive", 16'h0000, 16'(drive.sw));
      end_sim();
   end
endmodule
